/* File: bench/torque_command_mode_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: %s", $time, m); end end
module torque_command_mode_select_tb;
    import tqm_pkg::*;
    logic i_mclk = 1'b0, i_rst = 1'b1;
    logic [6:0] req_di = 7'h00, di;
    logic signed [15:0] req_ana = 16'sh0000, ana, cmd, lim;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, limv;
    logic [1:0] bresp, rresp;
    logic [5:0] mode;
    int num_errors = 0, compares = 0, cycles = 0;
    logic [15:0] pv [3] = '{16'h0064, 16'hff38, 16'h0190};
    logic [15:0] ex [3] = '{16'h0064, 16'hff38, 16'h012c};
    logic [13:0] tbl [19] = '{{4'h6,4'h1,6'h04}, {4'h6,4'h0,6'h01}, {4'h7,4'h2,6'h08},
        {4'h7,4'h0,6'h01}, {4'h8,4'h0,6'h02}, {4'h8,4'h1,6'h04}, {4'h9,4'h0,6'h02},
        {4'h9,4'h2,6'h08}, {4'ha,4'h4,6'h08}, {4'ha,4'h0,6'h04}, {4'hd,4'h8,6'h02},
        {4'hd,4'h0,6'h01}, {4'he,4'h8,6'h02}, {4'he,4'h1,6'h04}, {4'hf,4'h2,6'h08},
        {4'hf,4'h8,6'h02}, {4'h4,4'h0,6'h10}, {4'h1,4'h0,6'h02}, {4'hb,4'h0,6'h01}};

    always #20 i_mclk = ~i_mclk;

    tqm_host_model host (.i_mclk(i_mclk), .i_contacts(req_di), .i_level(req_ana),
        .o_contacts(di), .o_level(ana));

    tqm_torque_mode #(.P_TICK_CYCLES(4)) dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_torque_sel_bit0(di[0]), .i_torque_sel_bit1(di[1]),
        .i_servo_on(di[2]), .i_speed_position_switch(di[3]), .i_torque_position_switch(di[4]),
        .i_speed_torque_switch(di[5]), .i_pulse_register_switch(di[6]), .i_analog_ref(ana),
        .o_torque_cmd(cmd), .o_torque_limit(lim), .o_limit_valid(limv), .o_active_mode(mode),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'h3), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready));

    task automatic summarize();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Each task ends one edge after its handshake so the next one can reassert
    // Ready for the answer is raised late so the stalled response is exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge i_mclk);
        bready <= 1'b0;
        `CHK(bresp, er, "write response")
        @(posedge i_mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a; arvalid <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge i_mclk);
        rready <= 1'b0;
        `CHK(rresp, er, "read response")
        `CHK(rdata, ed, "read data")
        @(posedge i_mclk);
    endtask

    task automatic put(input logic [6:0] d, input logic signed [15:0] v);
        req_di <= d; req_ana <= v;
        repeat (20) @(posedge i_mclk);
    endtask

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        rd(8'h04, {16'h0, RST_FULL_SCALE}, RESP_OKAY);
        rd(8'h80, {26'h0, MODE_PT}, RESP_OKAY);
        rd(8'h60, 32'h0, RESP_SLVERR);
        wr(8'h84, 32'h1234, RESP_SLVERR);
        $display("test reset finished");
        wr(8'h28, 32'h000a, RESP_OKAY);
        rd(8'h28, {16'h0, NOTCH_FREQ_MIN}, RESP_OKAY);
        wr(8'h4c, 32'h1770, RESP_OKAY);
        rd(8'h4c, {16'h0, NOTCH_FREQ_MAX}, RESP_OKAY);
        wr(8'h2c, 32'h0028, RESP_OKAY);
        rd(8'h2c, {16'h0, NOTCH_ATT_MAX}, RESP_OKAY);
        rd(8'h1c, {16'h0, RST_NOTCH_FREQ}, RESP_OKAY);
        wr(8'h2c, 32'h0, RESP_OKAY);
        $display("test notch finished");
        wr(8'h04, 32'h012c, RESP_OKAY);
        wr(8'h00, 32'h3, RESP_OKAY);
        put(7'h04, 16'sh4000);
        `CHK(cmd, 16'h3a98, "analog half scale")
        `CHK(mode, MODE_T, "torque mode")
        put(7'h04, -16'sh4000);
        rd(8'h84, 32'hffffc568, RESP_OKAY);
        for (int i = 0; i < 3; i++) wr(8'(8'h0c + 4 * i), {16'h0, pv[i]}, RESP_OKAY);
        rd(8'h14, {16'h0, ex[2]}, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            put({5'h01, 2'(i + 1)}, 16'sh4000);
            `CHK(cmd, 16'(ex[i] * PCT_TO_CMD), "preset command")
        end
        rd(8'h8c, 32'h7, RESP_OKAY);
        $display("test torque finished");
        wr(8'h00, 32'h5, RESP_OKAY);
        put(7'h04, 16'sh4000);
        `CHK(cmd, 16'h0000, "zero mode ignores analog")
        `CHK(mode, MODE_TZ, "torque zero mode")
        put(7'h05, 16'sh4000);
        `CHK(cmd, 16'h2710, "zero mode preset")
        put(7'h01, 16'sh4000);
        `CHK(cmd, 16'h0000, "servo off")
        wr(8'h00, 32'h2, RESP_OKAY);
        put(7'h05, 16'sh0000);
        `CHK(lim, 16'h2710, "speed mode limit")
        `CHK(limv, 1'b1, "limit valid")
        $display("test zero finished");
        wr(8'h00, 32'h3, RESP_OKAY);
        put(7'h04, 16'sh0000);
        wr(8'h08, 32'h4, RESP_OKAY);
        put(7'h05, 16'sh0000);
        `CHK(cmd > 16'sh0000 && cmd < 16'sh2710, 1'b1, "smoothed ramp")
        wr(8'h08, 32'h0, RESP_OKAY);
        put(7'h05, 16'sh0000);
        `CHK(cmd, 16'h2710, "smoothing bypass")
        $display("test smoothing finished");
        for (int i = 0; i < 19; i++) begin
            wr(8'h00, {28'h0, tbl[i][13:10]}, RESP_OKAY);
            put({tbl[i][9:6], 3'h4}, 16'sh0000);
            `CHK(mode, tbl[i][5:0], "mode decode")
        end
        $display("test modes finished");
        summarize();
    end
endmodule // torque_command_mode_select_tb
`default_nettype wire

/* File: bench/tqm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tqm_host_model (
    // Clock
    input  wire logic               i_mclk,
    // Requested contact states and reference
    input  wire logic [6:0]         i_contacts,
    input  wire logic signed [15:0] i_level,
    // Lines into the drive
    output logic [6:0]              o_contacts = 7'h00,
    output logic signed [15:0]      o_level = 16'sh0000
);
    // Closed contact is 1, open is 0; reference is a differential sample
    always @(posedge i_mclk) begin
        o_contacts <= i_contacts;
        o_level <= i_level;
    end
    // Notches kept at zero depth, low-pass left off; speed limit lives elsewhere
endmodule // tqm_host_model
`default_nettype wire

/* File: bench/tqm_torque_mode_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tqm_torque_mode_props
    import tqm_pkg::*;
(
    // Clock and reset
    input wire logic               i_mclk,
    input wire logic               i_rst,
    // Contacts and datapath
    input wire logic               i_torque_sel_bit0,
    input wire logic               i_torque_sel_bit1,
    input wire logic               i_servo_on,
    input wire logic signed [15:0] o_torque_cmd,
    input wire logic               o_limit_valid,
    input wire logic [5:0]         o_active_mode,
    // Register bus
    input wire logic               i_awvalid,
    input wire logic               o_awready,
    input wire logic               i_wvalid,
    input wire logic               o_wready,
    input wire logic [1:0]         o_bresp,
    input wire logic               o_bvalid,
    input wire logic               i_bready,
    input wire logic               i_arvalid,
    input wire logic               o_arready,
    input wire logic [31:0]        o_rdata,
    input wire logic               o_rvalid,
    input wire logic               i_rready
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    logic       zero_cond;
    logic [4:0] nxt_zero_cnt;
    logic [4:0] zero_cnt_ff;
    // Long hold covers sync, pipeline and mode decode latency
    assign zero_cond = !i_servo_on || (o_active_mode inside {MODE_PT, MODE_PR})
        || (o_active_mode == MODE_TZ && !i_torque_sel_bit0 && !i_torque_sel_bit1);
    assign nxt_zero_cnt = (i_rst || !zero_cond) ? 5'h00 :
                          (zero_cnt_ff == 5'h14) ? zero_cnt_ff : zero_cnt_ff + 5'h01;
    always_ff @(posedge i_mclk) zero_cnt_ff <= nxt_zero_cnt;

    sequence s_wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_rd_taken;
        i_arvalid && o_arready;
    endsequence

    a_mode_onehot: assert property ($onehot(o_active_mode))
        else $error("active mode not one-hot");
    a_limit_speed_only: assert property
        ((!(o_active_mode inside {MODE_S, MODE_SZ}))[*4] |-> !o_limit_valid)
        else $error("limit valid outside speed mode");
    a_zero_cmd_hold: assert property (zero_cnt_ff == 5'h14 |-> o_torque_cmd == 16'sh0000)
        else $error("torque command not zero");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] o_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_rd_taken |-> ##[1:2] o_rvalid)
        else $error("read response late");
    a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    a_ar_blocked: assert property (o_rvalid |-> !o_arready)
        else $error("read address accepted during response");
    a_aw_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted during response");
endmodule // tqm_torque_mode_props

bind tqm_torque_mode tqm_torque_mode_props u_props (
    .i_mclk, .i_rst, .i_torque_sel_bit0, .i_torque_sel_bit1, .i_servo_on,
    .o_torque_cmd, .o_limit_valid, .o_active_mode, .i_awvalid, .o_awready,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid,
    .o_arready, .o_rdata, .o_rvalid, .i_rready
);
`default_nettype wire

/* File: design/tqm_pkg.sv */
package tqm_pkg;
    // Clock and timing
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          SMOOTH_TICK_NS  = 1000000;
    localparam int          SMOOTH_TICK_CYC = SMOOTH_TICK_NS / CLK_PERIOD_NS;

    // Configuration word indexes; byte address is four times the index
    localparam logic [4:0]  IDX_MODE        = 5'h00;
    localparam logic [4:0]  IDX_FULL_SCALE  = 5'h01;
    localparam logic [4:0]  IDX_SMOOTH      = 5'h02;
    localparam logic [4:0]  IDX_PRESET1     = 5'h03;
    localparam logic [4:0]  IDX_PRESET3     = 5'h05;
    localparam logic [4:0]  IDX_RES_LP      = 5'h06;
    localparam logic [4:0]  IDX_NOTCH_BASE  = 5'h07;
    localparam int          NUM_CFG         = 22;
    localparam int          NUM_NOTCH       = 5;
    // Status words sit at byte 0x80 and up
    localparam logic [1:0]  STS_MODE        = 2'h0;
    localparam logic [1:0]  STS_CMD         = 2'h1;
    localparam logic [1:0]  STS_LIMIT       = 2'h2;
    localparam logic [1:0]  STS_INPUTS      = 2'h3;

    // Reset values
    localparam logic [15:0] RST_MODE        = 16'h0000;
    localparam logic [15:0] RST_FULL_SCALE  = 16'h0064;
    localparam logic [15:0] RST_NOTCH_FREQ  = 16'h03e8;
    localparam logic [15:0] RST_ZERO        = 16'h0000;

    // Value limits
    localparam logic [15:0] FULL_SCALE_MAX  = 16'h012c;
    localparam logic signed [15:0] PRESET_MAX = 16'sh012c;
    localparam logic [15:0] NOTCH_FREQ_MIN  = 16'h0032;
    localparam logic [15:0] NOTCH_FREQ_MAX  = 16'h1388;
    localparam logic [15:0] NOTCH_ATT_MAX   = 16'h0020;
    localparam logic [15:0] PCT_TO_CMD      = 16'h0064;

    // Control mode setting values
    localparam logic [3:0]  CM_PT = 4'h0, CM_PR = 4'h1, CM_S = 4'h2, CM_T = 4'h3;
    localparam logic [3:0]  CM_SZ = 4'h4, CM_TZ = 4'h5, CM_PT_S = 4'h6, CM_PT_T = 4'h7;
    localparam logic [3:0]  CM_PR_S = 4'h8, CM_PR_T = 4'h9, CM_S_T = 4'ha;
    localparam logic [3:0]  CM_PULSE_REGISTER_SELECT = 4'hd, CM_PULSE_REGISTER_SELECT_S = 4'he, CM_PULSE_REGISTER_SELECT_T = 4'hf;

    // Synchronised input bit positions
    localparam int DI_SEL0 = 0, DI_SEL1 = 1, DI_SERVO = 2, DI_SP = 3;
    localparam int DI_TP = 4, DI_ST = 5, DI_PTPR = 6, DI_W = 7;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [5:0] {
        MODE_PT = 6'b000001,
        MODE_PR = 6'b000010,
        MODE_S  = 6'b000100,
        MODE_T  = 6'b001000,
        MODE_SZ = 6'b010000,
        MODE_TZ = 6'b100000
    } tqm_mode_t;
endpackage

/* File: design/tqm_torque_mode.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Mode setting 3 gives torque mode, 5 gives torque-zero mode.
// - Torque mode, select 00: command from differential analog reference, -10V..+10V.
// - Torque-zero mode, select 00: analog ignored, command held at zero.
// - Select 01/10/11 pick signed presets 1/2/3, each -300%..300%.
// - Preset takes effect when select inputs change, no trigger needed.
// - Select input reads 0 when contact open, 1 when closed.
// - In speed modes selected torque values act as torque limits.
// - Analog 10V equals full-scale percentage setting of rated torque.
// - Smoothing constant 0ms bypasses filter; otherwise low-pass the command.
// - Torque source selected from select inputs only while servo is on.
// - Decode 06,07,08,09,0A,0D as dual modes, 0E,0F as multiple modes.
// - Dual modes switch by inputs 0x18, 0x20, 0x19 and 0x2B.
// - Multiple modes combine mode switch and pulse/register switch inputs.
// - No speed-zero or torque-zero variant inside any dual mode.
// - Five independent notch filters, each with frequency, depth and bandwidth.
// - Notch frequency 50..5000 Hz, depth 0..32 dB accepted.
// - Resonance low-pass strengthens as its setting rises above zero.
module tqm_torque_mode
    import tqm_pkg::*;
#(
    parameter int P_TICK_CYCLES = SMOOTH_TICK_CYC
) (
    // Clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    // Digital input contacts, asynchronous
    input  wire logic               i_torque_sel_bit0,
    input  wire logic               i_torque_sel_bit1,
    input  wire logic               i_servo_on,
    input  wire logic               i_speed_position_switch,
    input  wire logic               i_torque_position_switch,
    input  wire logic               i_speed_torque_switch,
    input  wire logic               i_pulse_register_switch,
    // Analog reference sample, same clock, 32767 = +10V
    input  wire logic signed [15:0] i_analog_ref,
    // Outputs to the loops
    output logic signed [15:0]      o_torque_cmd,
    output logic signed [15:0]      o_torque_limit,
    output logic                    o_limit_valid,
    output logic [5:0]              o_active_mode,
    // AXI4-Lite slave
    input  wire logic [7:0]         i_awaddr,
    input  wire logic               i_awvalid,
    output logic                    o_awready,
    input  wire logic [31:0]        i_wdata,
    input  wire logic [3:0]         i_wstrb,
    input  wire logic               i_wvalid,
    output logic                    o_wready,
    output logic [1:0]              o_bresp,
    output logic                    o_bvalid,
    input  wire logic               i_bready,
    input  wire logic [7:0]         i_araddr,
    input  wire logic               i_arvalid,
    output logic                    o_arready,
    output logic [31:0]             o_rdata,
    output logic [1:0]              o_rresp,
    output logic                    o_rvalid,
    input  wire logic               i_rready
);
    function automatic logic [3:0] msb_of(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int b = 0; b < 16; b++) begin
            if (v[b]) begin
                r = 4'(b);
            end
        end
        return r;
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [23:0] v);
        if (v > 24'sd32767) begin
            return 16'sh7fff;
        end else if (v < -24'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction

    // Result always lies between y and x, so it fits the width
    function automatic logic signed [15:0] lp_step(input logic signed [15:0] y,
                                                   input logic signed [15:0] x,
                                                   input logic [3:0] k);
        logic signed [16:0] d;
        d = 17'(x) - 17'(y);
        return 16'(17'(y) + (d >>> k));
    endfunction

    // Out-of-range writes are clamped rather than refused
    function automatic logic [15:0] clamp_cfg(input logic [4:0] idx, input logic [15:0] v);
        logic [4:0] fld;
        fld = 5'(5'(idx - IDX_NOTCH_BASE) % 5'd3);
        if (idx == IDX_MODE) begin
            return {12'h000, v[3:0]};
        end else if (idx == IDX_FULL_SCALE) begin
            return (v > FULL_SCALE_MAX) ? FULL_SCALE_MAX : v;
        end else if (idx >= IDX_PRESET1 && idx <= IDX_PRESET3) begin
            if ($signed(v) > PRESET_MAX) return PRESET_MAX;
            if ($signed(v) < -PRESET_MAX) return -PRESET_MAX;
            return v;
        end else if (idx < IDX_NOTCH_BASE || fld == 5'd2) begin
            return v;
        end else if (fld == 5'd0) begin
            if (v < NOTCH_FREQ_MIN) return NOTCH_FREQ_MIN;
            return (v > NOTCH_FREQ_MAX) ? NOTCH_FREQ_MAX : v;
        end
        return (v > NOTCH_ATT_MAX) ? NOTCH_ATT_MAX : v;
    endfunction

    // Input synchroniser; the first stage feeds only the second
    logic [DI_W-1:0] sync1_ff;
    logic [DI_W-1:0] di_ff;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync1_ff <= '0;
            di_ff    <= '0;
        end else begin
            sync1_ff <= {i_pulse_register_switch, i_speed_torque_switch,
                         i_torque_position_switch, i_speed_position_switch,
                         i_servo_on, i_torque_sel_bit1, i_torque_sel_bit0};
            di_ff    <= sync1_ff;
        end
    end

    // Configuration storage
    logic [15:0] cfg_ff [0:NUM_CFG-1];
    wire  [3:0]  mode_set = cfg_ff[IDX_MODE][3:0];
    wire         sw_sp    = di_ff[DI_SP];
    wire         sw_tp    = di_ff[DI_TP];
    wire         sw_st    = di_ff[DI_ST];
    wire         sw_ptpr  = di_ff[DI_PTPR];
    wire         pos_sel  = sw_ptpr ? 1'b1 : 1'b0;

    // Operating mode decode; zero variants only in single modes
    tqm_mode_t   mode_nxt;
    always_comb begin
        unique case (mode_set)
            CM_PR:      mode_nxt = MODE_PR;
            CM_S:       mode_nxt = MODE_S;
            CM_T:       mode_nxt = MODE_T;
            CM_SZ:      mode_nxt = MODE_SZ;
            CM_TZ:      mode_nxt = MODE_TZ;
            CM_PT_S:    mode_nxt = sw_sp ? MODE_S : MODE_PT;
            CM_PT_T:    mode_nxt = sw_tp ? MODE_T : MODE_PT;
            CM_PR_S:    mode_nxt = sw_sp ? MODE_S : MODE_PR;
            CM_PR_T:    mode_nxt = sw_tp ? MODE_T : MODE_PR;
            CM_S_T:     mode_nxt = sw_st ? MODE_T : MODE_S;
            CM_PULSE_REGISTER_SELECT:   mode_nxt = pos_sel ? MODE_PR : MODE_PT;
            CM_PULSE_REGISTER_SELECT_S: mode_nxt = sw_sp ? MODE_S : (pos_sel ? MODE_PR : MODE_PT);
            CM_PULSE_REGISTER_SELECT_T: mode_nxt = sw_tp ? MODE_T : (pos_sel ? MODE_PR : MODE_PT);
            default:    mode_nxt = MODE_PT;
        endcase
    end

    // Source selection and analog scaling
    wire  [1:0]         tsel      = {di_ff[DI_SEL1], di_ff[DI_SEL0]};
    wire                servo     = di_ff[DI_SERVO];
    wire  signed [33:0] ana_prod  = 34'(i_analog_ref) * 34'(cfg_ff[IDX_FULL_SCALE])
                                    * 34'(PCT_TO_CMD);
    wire  signed [15:0] ana_cmd   = 16'(ana_prod >>> 15);
    wire  signed [23:0] pre_prod  = 24'($signed(cfg_ff[IDX_PRESET1 + 5'(tsel) - 5'd1]))
                                    * 24'(PCT_TO_CMD);
    wire  signed [15:0] pre_cmd   = sat16(pre_prod);
    wire                zero_src  = (mode_nxt == MODE_TZ) || (mode_nxt == MODE_SZ);
    wire  signed [15:0] src_nxt   = !servo         ? 16'sh0000 :
                                    (tsel != 2'h0) ? pre_cmd :
                                    zero_src       ? 16'sh0000 : ana_cmd;
    wire                is_torque = (mode_nxt == MODE_T) || (mode_nxt == MODE_TZ);
    wire                is_speed  = (mode_nxt == MODE_S) || (mode_nxt == MODE_SZ);

    tqm_mode_t          mode_ff;
    logic signed [15:0] cmd_src_ff;
    logic signed [15:0] limit_ff;
    logic               limit_vld_ff;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mode_ff      <= MODE_PT;
            cmd_src_ff   <= '0;
            limit_ff     <= '0;
            limit_vld_ff <= 1'b0;
        end else begin
            mode_ff      <= mode_nxt;
            cmd_src_ff   <= is_torque ? src_nxt : 16'sh0000;
            limit_ff     <= is_speed ? src_nxt : 16'sh0000;
            limit_vld_ff <= is_speed & servo;
        end
    end

    // Command smoothing, stepped once per millisecond
    logic [15:0]        tick_cnt_ff;
    logic signed [15:0] smooth_ff;
    wire                tick    = (tick_cnt_ff == 16'(P_TICK_CYCLES - 1));
    wire  [15:0]        sm_cfg  = cfg_ff[IDX_SMOOTH];
    wire  [3:0]         sm_k    = (msb_of(sm_cfg) == 4'hf) ? 4'hf : msb_of(sm_cfg) + 4'h1;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tick_cnt_ff <= '0;
            smooth_ff   <= '0;
        end else begin
            tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
            if (sm_cfg == 16'h0000) begin
                smooth_ff <= cmd_src_ff;
            end else if (tick) begin
                smooth_ff <= lp_step(smooth_ff, cmd_src_ff, sm_k);
            end
        end
    end

    // Notch chain; depth 0 passes unchanged and DC gain is never altered
    logic signed [15:0] notch_lp_ff [0:NUM_NOTCH-1];
    logic signed [15:0] notch_y_ff  [0:NUM_NOTCH-1];
    always_ff @(posedge i_mclk) begin
        for (int n = 0; n < NUM_NOTCH; n++) begin
            automatic logic signed [15:0] x  = (n == 0) ? smooth_ff : notch_y_ff[(n == 0) ? 0 : n - 1];
            automatic logic [15:0]        fq = cfg_ff[IDX_NOTCH_BASE + 5'(3 * n)];
            automatic logic [15:0]        at = cfg_ff[IDX_NOTCH_BASE + 5'(3 * n + 1)];
            automatic logic [15:0]        bw = cfg_ff[IDX_NOTCH_BASE + 5'(3 * n + 2)];
            automatic logic [3:0]         k0 = 4'hf - msb_of(fq);
            automatic logic [3:0]         k  = (k0 > {2'b00, bw[1:0]}) ? k0 - {2'b00, bw[1:0]}
                                                                      : 4'h1;
            automatic logic signed [23:0] hp = (24'(x) - 24'(notch_lp_ff[n])) * 24'(at[5:0]);
            if (i_rst) begin
                notch_lp_ff[n] <= '0;
                notch_y_ff[n]  <= '0;
            end else begin
                notch_lp_ff[n] <= lp_step(notch_lp_ff[n], x, k);
                notch_y_ff[n]  <= sat16(24'(x) - (hp >>> 5));
            end
        end
    end

    // Resonance low-pass; larger setting means narrower bandwidth
    logic signed [15:0] res_ff;
    logic signed [15:0] out_ff;
    wire  [15:0]        rl_cfg = cfg_ff[IDX_RES_LP];
    wire  [3:0]         rl_k   = (msb_of(rl_cfg) == 4'hf) ? 4'hf : msb_of(rl_cfg) + 4'h1;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            res_ff <= '0;
            out_ff <= '0;
        end else begin
            res_ff <= (rl_cfg == 16'h0000) ? notch_y_ff[NUM_NOTCH-1]
                      : lp_step(res_ff, notch_y_ff[NUM_NOTCH-1], rl_k);
            out_ff <= res_ff;
        end
    end

    // AXI4-Lite slave, one write and one read at a time
    logic       awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic       aw_got_ff, w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    wire        aw_take   = i_awvalid & awready_ff;
    wire        w_take    = i_wvalid & wready_ff;
    wire        wr_go     = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire        nxt_aw    = ~wr_go & (aw_got_ff | aw_take);
    wire        nxt_w     = ~wr_go & (w_got_ff | w_take);
    wire        nxt_bv    = wr_go | (bvalid_ff & ~i_bready);
    wire        ar_take   = i_arvalid & arready_ff;
    wire        nxt_rv    = ar_take | (rvalid_ff & ~i_rready);
    wire  [4:0] wr_idx    = awaddr_ff[6:2];
    wire        wr_ok     = ~awaddr_ff[7] && (wr_idx < 5'(NUM_CFG));
    wire  [15:0] wr_old   = cfg_ff[wr_ok ? wr_idx : 5'h00];
    wire  [15:0] wr_merge = {wstrb_ff[1] ? wdata_ff[15:8] : wr_old[15:8],
                             wstrb_ff[0] ? wdata_ff[7:0]  : wr_old[7:0]};
    wire  [4:0] rd_idx    = i_araddr[6:2];
    wire        rd_cfg    = ~i_araddr[7] && (rd_idx < 5'(NUM_CFG));
    wire        rd_sts    = i_araddr[7] && (i_araddr[6:4] == 3'h0);
    wire  [1:0] sts_sel   = i_araddr[3:2];
    wire  [31:0] sts_word = (sts_sel == STS_MODE)  ? {26'h0, mode_ff} :
                            (sts_sel == STS_CMD)   ? 32'(out_ff) :
                            (sts_sel == STS_LIMIT) ? 32'(limit_ff) : {25'h0, di_ff};
    wire  [31:0] rd_word  = rd_cfg ? {16'h0000, cfg_ff[rd_cfg ? rd_idx : 5'h00]} :
                            rd_sts ? sts_word : 32'h0000_0000;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
            bresp_ff   <= RESP_OKAY;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= '0;
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_ff[i] <= RST_ZERO;
            end
            cfg_ff[IDX_MODE]       <= RST_MODE;
            cfg_ff[IDX_FULL_SCALE] <= RST_FULL_SCALE;
            for (int n = 0; n < NUM_NOTCH; n++) begin
                cfg_ff[IDX_NOTCH_BASE + 5'(3 * n)] <= RST_NOTCH_FREQ;
            end
        end else begin
            aw_got_ff  <= nxt_aw;
            w_got_ff   <= nxt_w;
            awready_ff <= ~nxt_aw & ~nxt_bv;
            wready_ff  <= ~nxt_w & ~nxt_bv;
            bvalid_ff  <= nxt_bv;
            arready_ff <= ~nxt_rv;
            rvalid_ff  <= nxt_rv;
            if (aw_take) begin
                awaddr_ff <= i_awaddr;
            end
            if (w_take) begin
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (wr_go) begin
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                if (wr_ok) begin
                    cfg_ff[wr_idx] <= clamp_cfg(wr_idx, wr_merge);
                end
            end
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= (rd_cfg | rd_sts) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign o_torque_cmd   = out_ff;
    assign o_torque_limit = limit_ff;
    assign o_limit_valid  = limit_vld_ff;
    assign o_active_mode  = mode_ff;
    assign o_awready      = awready_ff;
    assign o_wready       = wready_ff;
    assign o_bresp        = bresp_ff;
    assign o_bvalid       = bvalid_ff;
    assign o_arready      = arready_ff;
    assign o_rdata        = rdata_ff;
    assign o_rresp        = rresp_ff;
    assign o_rvalid       = rvalid_ff;
endmodule // tqm_torque_mode
`default_nettype wire
